// ===== rtl/comparator_channel.sv
`include "cmp_params.svh"
`default_nettype none

module comparator_channel
(
  input wire logic   mclk,
  input wire logic   resetn,
  cmp_channel_if.chan ch
);
  import cmp_pkg::*;

  // Checks below sample on the rising clock and pause during reset.
  default clocking chk_clk @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  logic raw_s1_q;
  logic raw_s2_q;
  logic tclk_s1_q;
  logic tclk_s2_q;
  logic tclk_s3_q;
  logic result_q;
  logic timer_q;
  wire  tclk_fall;
  wire  pol_result;

  // ==========================================================
  // Synchronisers for the analog result and the timer clock.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      raw_s1_q  <= 1'b0;
      raw_s2_q  <= 1'b0;
      tclk_s1_q <= 1'b0;
      tclk_s2_q <= 1'b0;
      tclk_s3_q <= 1'b0;
    end
    else
    begin
      raw_s1_q  <= ch.raw_result;
      raw_s2_q  <= raw_s1_q;
      tclk_s1_q <= ch.timer_clk;
      tclk_s2_q <= tclk_s1_q;
      tclk_s3_q <= tclk_s2_q;
    end
  end

  // A disabled comparator gives zero before the polarity stage.
  assign pol_result = (ch.enable & raw_s2_q) ^ ch.invert;
  // Falling edge of the prescaled timer clock.
  assign tclk_fall  = tclk_s3_q & ~tclk_s2_q;

  // ==========================================================
  // Result latched every cycle; timer copy latched on the fall in sync mode, every cycle otherwise.
  // The reset level is a convenience only; the first valid
  // level after enabling is not guaranteed.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      result_q <= 1'b0;
      timer_q  <= 1'b0;
    end
    else
    begin
      result_q <= pol_result;
      if (!ch.sync_sel || tclk_fall)
      begin
        timer_q <= pol_result;
      end
    end
  end

  assign ch.result       = result_q;
  assign ch.timer_result = timer_q;

  // ==========================================================
  // Checks on the channel.
  a_result_follows_raw: assert property (
    (ch.enable && !ch.invert && ch.raw_result)[*4] |-> ch.result)
    else $error("Result did not follow a steady raw high.");
  a_invert_flips: assert property (
    (ch.enable && ch.invert && ch.raw_result)[*4] |-> !ch.result)
    else $error("Inverted result is not low for raw high.");
  a_disabled_low: assert property (
    (!ch.enable && !ch.invert)[*2] |-> !ch.result)
    else $error("Disabled comparator result is not low.");
  a_sync_hold: assert property (
    (ch.sync_sel && !tclk_fall) |=> $stable(ch.timer_result))
    else $error("Timer result changed without a timer clock fall.");
  c_sync_latch: cover property (
    ch.sync_sel && tclk_fall ##1 $changed(ch.timer_result));

endmodule

`default_nettype wire

// ===== rtl/comparator_control_output.sv
// Function
// - Each result drives its own dedicated pin.
// - Either or both results feed PWM shutdown.
// - Results usable as closed-loop PWM restart feedback.
// - Initial result level is undefined.
// - Bit 1 enables hysteresis.
// - Analog-configured pins read back as zero.
// - Polarity bit inverts result.
// - Sync mode latches on timer clock fall.
// - Pin driven when enable, pin-enable, direction clear.
// - Speed/power bit resets to one.
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`include "cmp_params.svh"
`default_nettype none

module comparator_control_output
#(
  parameter int PORT_W = 8
)
(
  input  wire logic                     mclk,
  input  wire logic                     resetn,
  input  wire logic [`CMP_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [`CMP_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic [1:0]               raw_result,
  input  wire logic                     timer_clk,
  input  wire logic [1:0]               pin_direction_bit,
  input  wire logic [1:0]               port_latch,
  input  wire logic [PORT_W-1:0]        port_pins,
  output logic                          first_result_pin_out,
  output logic                          first_result_pin_oe,
  output logic                          second_result_pin_out,
  output logic                          second_result_pin_oe,
  output logic [1:0]                    comparator_enable,
  output logic [1:0]                    speed_power_select,
  output logic [1:0]                    hysteresis_enable,
  output logic [1:0]                    shutdown_source,
  output logic [1:0]                    timer_result,
  output logic [PORT_W-1:0]             analog_select
);
  import cmp_pkg::*;

  // Checks below sample on the rising clock and pause during reset, except a_speed_reset.
  default clocking chk_clk @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  // Decodes a byte address to a register select.
  function automatic reg_sel_type decode(input logic [`CMP_ADDR_W-1:0] a);
    unique case (a)
      `CMP_OFF_CTRL0:  decode = SEL_CTRL0;
      `CMP_OFF_CTRL1:  decode = SEL_CTRL1;
      `CMP_OFF_PORT:   decode = SEL_PORT;
      `CMP_OFF_ANALOG: decode = SEL_ANALOG;
      default:         decode = SEL_NONE;
    endcase
  endfunction

  ctrl_type                 ctrl_q [2];
  logic [PORT_W-1:0]        analog_q;
  logic [PORT_W-1:0]        port_s1_q;
  logic [PORT_W-1:0]        port_s2_q;
  logic                     aw_hold_q;
  logic                     w_hold_q;
  logic [`CMP_ADDR_W-1:0]   awaddr_q;
  logic [7:0]               wdata_q;
  logic                     wstrb_q;
  logic                     bvalid_q;
  axi_resp_type             bresp_q;
  logic                     rvalid_q;
  axi_resp_type             rresp_q;
  logic [31:0]              rdata_q;
  logic [1:0]               result;

  // ==========================================================
  // Comparator channels.
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : chan
      cmp_channel_if cif ();
      assign cif.enable     = ctrl_q[g][`CMP_BIT_EN];
      assign cif.invert     = ctrl_q[g][`CMP_BIT_INV];
      assign cif.sync_sel   = ctrl_q[g][`CMP_BIT_SYNC];
      assign cif.raw_result = raw_result[g];
      assign cif.timer_clk  = timer_clk;
      assign result[g]       = cif.result;
      assign timer_result[g] = cif.timer_result;
      assign comparator_enable[g]  = ctrl_q[g][`CMP_BIT_EN];
      assign speed_power_select[g] = ctrl_q[g][`CMP_BIT_SP];
      assign hysteresis_enable[g]  = ctrl_q[g][`CMP_BIT_HYS];
      comparator_channel u_chan
      (
        .mclk   (mclk),
        .resetn (resetn),
        .ch     (cif.chan)
      );
    end
  endgenerate

  // ==========================================================
  // Pin and PWM outputs; the result overrides the port latch only while pin_oe is set.
  wire [1:0] pin_oe = {ctrl_q[1][`CMP_BIT_PINEN], ctrl_q[0][`CMP_BIT_PINEN]}
                      & comparator_enable & ~pin_direction_bit;
  assign first_result_pin_oe   = pin_oe[0];
  assign second_result_pin_oe  = pin_oe[1];
  assign first_result_pin_out  = pin_oe[0] ? result[0] : port_latch[0];
  assign second_result_pin_out = pin_oe[1] ? result[1] : port_latch[1];
  assign shutdown_source       = result;
  assign analog_select         = analog_q;

  // ==========================================================
  // Write channel: address and data taken in either order.
  assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready  = ~w_hold_q & ~bvalid_q;
  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire wr_fire  = (aw_hold_q | aw_take) & (w_hold_q | w_take);
  wire [`CMP_ADDR_W-1:0] wr_addr = aw_hold_q ? awaddr_q : s_axi_awaddr;
  wire [7:0]  wr_data = w_hold_q ? wdata_q : s_axi_wdata[7:0];
  wire        wr_strb = w_hold_q ? wstrb_q : s_axi_wstrb[0];
  wire reg_sel_type wr_sel = decode(wr_addr);
  wire ctrl_type wmask = `CMP_CTRL_WMASK;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      bvalid_q  <= 1'b1;
      bresp_q   <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata[7:0];
        wstrb_q  <= s_axi_wstrb[0];
      end
      if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // ==========================================================
  // Register storage; only byte lane 0 carries data.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_q[0] <= `CMP_CTRL_RST;
      ctrl_q[1] <= `CMP_CTRL_RST;
      analog_q  <= '1;
    end
    else if (wr_fire && wr_strb)
    begin
      case (wr_sel)
        SEL_CTRL0:  ctrl_q[0] <= (ctrl_q[0] & ~wmask) | (wr_data & wmask);
        SEL_CTRL1:  ctrl_q[1] <= (ctrl_q[1] & ~wmask) | (wr_data & wmask);
        SEL_ANALOG: analog_q  <= wr_data[PORT_W-1:0];
        default:    ;
      endcase
    end
  end

  // Port pins come from outside and pass two flip-flops.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      port_s1_q <= '0;
      port_s2_q <= '0;
    end
    else
    begin
      port_s1_q <= port_pins;
      port_s2_q <= port_s1_q;
    end
  end

  // ==========================================================
  // Read channel: one read at a time, answered one cycle later.
  assign s_axi_arready = ~rvalid_q;
  wire reg_sel_type rd_sel = decode(s_axi_araddr);
  wire ctrl_type rd_ctrl0 = (ctrl_q[0] & wmask)
                            | (ctrl_type'(result[0]) << `CMP_BIT_RESULT);
  wire ctrl_type rd_ctrl1 = (ctrl_q[1] & wmask)
                            | (ctrl_type'(result[1]) << `CMP_BIT_RESULT);
  wire [PORT_W-1:0] port_view = port_s2_q & ~analog_q;
  wire [31:0] rd_word =
    (rd_sel == SEL_CTRL0)  ? {24'h000000, rd_ctrl0} :
    (rd_sel == SEL_CTRL1)  ? {24'h000000, rd_ctrl1} :
    (rd_sel == SEL_PORT)   ? {{(32-PORT_W){1'b0}}, port_view} :
    (rd_sel == SEL_ANALOG) ? {{(32-PORT_W){1'b0}}, analog_q} : 32'h00000000;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= '0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      rdata_q  <= rd_word;
    end
    else if (s_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_rdata  = rdata_q;

  // ==========================================================
  // Checks on registers and pins.
  a_pin_drive_cond: assert property (first_result_pin_oe |->
    comparator_enable[0] && !pin_direction_bit[0]
    && first_result_pin_out == result[0])
    else $error("Result pin driven without its enables.");
  a_pin_off_latch: assert property (!ctrl_q[1][`CMP_BIT_PINEN] |->
    !second_result_pin_oe && second_result_pin_out == port_latch[1])
    else $error("Second pin not released to the port latch.");
  a_port_analog_zero: assert property (
    s_axi_arvalid && s_axi_arready && rd_sel == SEL_PORT
    |=> (s_axi_rdata[PORT_W-1:0] & $past(analog_q)) == '0)
    else $error("Analog pin read back as non-zero.");
  a_reserved_zero: assert property (
    s_axi_arvalid && s_axi_arready && rd_sel == SEL_CTRL0
    |=> !s_axi_rdata[3] && s_axi_rdata[6] == $past(result[0]))
    else $error("Control read has wrong bit 3 or result bit.");
  a_hyst_write: assert property (
    wr_fire && wr_strb && wr_sel == SEL_CTRL1
    |=> hysteresis_enable[1] == $past(wr_data[`CMP_BIT_HYS]))
    else $error("Hysteresis did not follow the write.");
  a_speed_reset: assert property (disable iff (1'b0)
    !resetn ##1 resetn |-> speed_power_select == 2'h3)
    else $error("Speed bit not one after reset.");
  a_write_resp: assert property (
    wr_fire |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("Write not answered one cycle later.");
  a_shutdown_src: assert property (
    (!comparator_enable[0] && !ctrl_q[0][`CMP_BIT_INV])[*3]
    |-> !shutdown_source[0])
    else $error("Disabled comparator still requests shutdown.");
  c_pin_driven: cover property (first_result_pin_oe && second_result_pin_oe);
  c_write_apart: cover property (aw_take && !w_take ##1 w_take);
  c_shutdown_both: cover property (shutdown_source == 2'h3);

endmodule

`default_nettype wire

// ===== shared/cmp_channel_if.sv
`default_nettype none

// ==========================================================
// Signals between the register block and one comparator channel.
interface cmp_channel_if;
  logic enable;
  logic invert;
  logic sync_sel;
  logic raw_result;
  logic timer_clk;
  logic result;
  logic timer_result;

  modport ctrl
  (
    output enable, invert, sync_sel, raw_result, timer_clk,
    input  result, timer_result
  );

  modport chan
  (
    input  enable, invert, sync_sel, raw_result, timer_clk,
    output result, timer_result
  );
endinterface

`default_nettype wire

// ===== shared/cmp_params.svh
`ifndef CMP_PARAMS_SVH
`define CMP_PARAMS_SVH

// ==========================================================
// Register map, byte addresses on the register bus.
`define CMP_ADDR_W      4
`define CMP_OFF_CTRL0   4'h0
`define CMP_OFF_CTRL1   4'h4
`define CMP_OFF_PORT    4'h8
`define CMP_OFF_ANALOG  4'hC

// ==========================================================
// Field positions of a comparator control register.
`define CMP_BIT_EN      7
`define CMP_BIT_RESULT  6
`define CMP_BIT_PINEN   5
`define CMP_BIT_INV     4
`define CMP_BIT_SP      2
`define CMP_BIT_HYS     1
`define CMP_BIT_SYNC    0

// Reset value: only the speed/power bit is set.
`define CMP_CTRL_RST    8'h04
// Writable bits: the result bit and bit 3 ignore writes.
`define CMP_CTRL_WMASK  8'hB7

`endif

// ===== shared/cmp_pkg.sv
`default_nettype none

// ==========================================================
// Types shared by the comparator control files.
package cmp_pkg;

  typedef logic [7:0] ctrl_type;

  typedef enum logic [1:0]
  {
    RESP_OKAY   = 2'h0,
    RESP_SLVERR = 2'h2
  } axi_resp_type;

  typedef enum logic [2:0]
  {
    SEL_CTRL0  = 3'h0,
    SEL_CTRL1  = 3'h1,
    SEL_PORT   = 3'h3,
    SEL_ANALOG = 3'h2,
    SEL_NONE   = 3'h6
  } reg_sel_type;

endpackage

`default_nettype wire

// ===== testbench/pwm_timer_model.sv
`default_nettype none

// ==========================================================
// Far side: PWM auto-shutdown with auto-restart, and the timer clock.
module pwm_timer_model
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       run,
  input  wire logic [1:0] shutdown_sel,
  input  wire logic [1:0] shutdown_source,
  output logic            timer_clk,
  output logic            pwm_active
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] div_q;

  // The prescaled timer clock idles high and toggles every fourth cycle.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      div_q     <= 2'h0;
      timer_clk <= 1'b1;
    end
    else if (run)
    begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3)
        timer_clk <= ~timer_clk;
    end
    else
      timer_clk <= 1'b1;
  end

  // Any selected source stops the PWM, which restarts once all clear.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      pwm_active <= 1'b1;
    else
      pwm_active <= ((shutdown_source & shutdown_sel) == 2'h0);
  end
endmodule

`default_nettype wire

// ===== testbench/tb_top.sv
`include "cmp_params.svh"
`default_nettype none

`define CHK(g, e) check(32'(g), 32'(e))

// ==========================================================
// Self-checking bench for the comparator control block.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cmp_pkg::*;

  typedef struct packed
  {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic [7:0] rexp;
  } row_type;

  logic        mclk, resetn, run, timer_clk, pwm_active;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs, raw_result, pin_direction_bit;
  logic [1:0]  port_latch, comparator_enable, speed_power_select;
  logic [1:0]  hysteresis_enable, shutdown_source, timer_result;
  logic [7:0]  port_pins, analog_select;
  logic        first_result_pin_out, first_result_pin_oe;
  logic        second_result_pin_out, second_result_pin_oe;
  int          failures = 0;
  int          total_checks = 0;

  // Writes with both comparator inputs low, and the expected readback.
  row_type rows [5] = '{
    '{`CMP_OFF_CTRL0, 8'hFF, 8'hF7},
    '{`CMP_OFF_CTRL0, 8'h48, 8'h00},
    '{`CMP_OFF_CTRL0, 8'h10, 8'h50},
    '{`CMP_OFF_CTRL1, 8'h86, 8'h86},
    '{`CMP_OFF_ANALOG, 8'h0F, 8'h0F}
  };

  comparator_control_output #(.PORT_W(8)) i_comparator_control_output
  (
    .mclk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .raw_result, .timer_clk,
    .pin_direction_bit, .port_latch, .port_pins, .first_result_pin_out,
    .first_result_pin_oe, .second_result_pin_out, .second_result_pin_oe,
    .comparator_enable, .speed_power_select, .hysteresis_enable,
    .shutdown_source, .timer_result, .analog_select
  );

  pwm_timer_model i_pwm_timer_model
  (
    .mclk, .resetn, .run, .shutdown_sel(2'h3), .shutdown_source,
    .timer_clk, .pwm_active
  );

  // ==========================================================
  // Clock, watchdog and shared tasks.
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // A run of well under a thousand cycles; a hang ends it here.
  initial
  begin
    repeat (4000) @(posedge mclk);
    failures++;
    close_out();
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (failures == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // One write: address and data go up together, each drops when taken.
  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    input logic [3:0] s = 4'hF);
    logic aw_left;
    logic w_left;
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_wstrb   <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    aw_left = 1'b1;
    w_left  = 1'b1;
    while (aw_left || w_left)
    begin
      @(posedge mclk);
      if (aw_left && s_axi_awready === 1'b1)
      begin
        s_axi_awvalid <= 1'b0;
        aw_left = 1'b0;
      end
      if (w_left && s_axi_wready === 1'b1)
      begin
        s_axi_wvalid <= 1'b0;
        w_left = 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1)
      @(posedge mclk);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // One read; data and response are taken at the rvalid edge.
  task automatic rd_reg(input logic [3:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
      @(posedge mclk);
    while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1)
      @(posedge mclk);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    rd_reg(a);
    `CHK(rs, RESP_OKAY);
    `CHK(rd, e);
  endtask

  // ==========================================================
  // Main sequence.
  initial
  begin
    resetn = 1'b0;
    {run, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, raw_result, port_latch} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
    pin_direction_bit = 2'h3;
    port_pins = 8'h00;
    cyc(2);
    resetn <= 1'b1;
    foreach (rows[i])
    begin
      wr(rows[i].addr, rows[i].wdata);
      cyc(4);
      rd_chk(rows[i].addr, rows[i].rexp);
    end
    `CHK(analog_select, 8'h0F);
    `CHK(comparator_enable, 2'h2);
    `CHK(hysteresis_enable, 2'h2);
    `CHK(speed_power_select, 2'h2);
    port_pins <= 8'hA5;
    cyc(4);
    rd_chk(`CMP_OFF_PORT, 8'hA0);
    // The result is read back before the PWM reaction is trusted.
    raw_result <= 2'h1;
    wr(`CMP_OFF_CTRL0, 8'h80);
    cyc(6);
    rd_chk(`CMP_OFF_CTRL0, 8'hC0);
    `CHK(shutdown_source, 2'h1);
    `CHK(pwm_active, 1'b0);
    raw_result <= 2'h3;
    cyc(6);
    `CHK(shutdown_source, 2'h3);
    raw_result <= 2'h0;
    cyc(6);
    `CHK(pwm_active, 1'b1);
    wr(`CMP_OFF_CTRL0, 8'h90);
    cyc(6);
    rd_chk(`CMP_OFF_CTRL0, 8'hD0);
    `CHK(shutdown_source, 2'h1);
    raw_result <= 2'h1;
    cyc(6);
    `CHK(shutdown_source, 2'h0);
    // Pins: the result overrides the port latch only when driven.
    port_latch <= 2'h2;
    pin_direction_bit <= 2'h0;
    raw_result <= 2'h1;
    wr(`CMP_OFF_CTRL0, 8'hA0);
    wr(`CMP_OFF_CTRL1, 8'hA0);
    cyc(6);
    `CHK({first_result_pin_oe, first_result_pin_out}, 2'h3);
    `CHK({second_result_pin_oe, second_result_pin_out}, 2'h2);
    pin_direction_bit <= 2'h1;
    cyc(3);
    `CHK({first_result_pin_oe, first_result_pin_out}, 2'h0);
    wr(`CMP_OFF_CTRL1, 8'h20);
    cyc(3);
    `CHK({second_result_pin_oe, second_result_pin_out}, 2'h1);
    // Timer mode: the latched copy waits for a falling timer edge.
    raw_result <= 2'h0;
    cyc(6);
    wr(`CMP_OFF_CTRL0, 8'h81);
    raw_result <= 2'h1;
    cyc(8);
    `CHK(timer_result[0], 1'b0);
    rd_chk(`CMP_OFF_CTRL0, 8'hC1);
    run <= 1'b1;
    cyc(12);
    run <= 1'b0;
    cyc(6);
    `CHK(timer_result, 2'h1);
    // A write without its low byte strobe changes nothing.
    wr(`CMP_OFF_CTRL0, 8'h00, 4'h0);
    `CHK(rs, RESP_OKAY);
    rd_chk(`CMP_OFF_CTRL0, 8'hC1);
    wr(4'h2, 8'h55);
    `CHK(rs, RESP_SLVERR);
    rd_reg(4'h2);
    `CHK(rs, RESP_SLVERR);
    `CHK(rd, 32'h0);
    // A second reset in mid-run restores the documented values.
    resetn <= 1'b0;
    cyc(2);
    resetn <= 1'b1;
    rd_chk(`CMP_OFF_CTRL0, `CMP_CTRL_RST);
    rd_chk(`CMP_OFF_CTRL1, `CMP_CTRL_RST);
    rd_chk(`CMP_OFF_ANALOG, 8'hFF);
    `CHK(speed_power_select, 2'h3);
    `CHK(analog_select, 8'hFF);
    close_out();
  end
endmodule

`default_nettype wire
